// ### core/asa_pkg.sv
package asa_pkg;
  localparam int          ASA_AW          = 12;
  localparam int          ASA_DW          = 8;
  localparam int          ASA_NFLAG       = 6;
  localparam int          ASA_NLANE       = 16;
  localparam logic [11:0] ASA_OFS_SUMMARY = 12'h2c0;
  localparam logic [11:0] ASA_OFS_FLAGS   = 12'h2c1;
  localparam logic [11:0] ASA_OFS_MASKS   = 12'h2c2;
  localparam logic [11:0] ASA_OFS_LANES   = 12'h2c4;
  localparam logic [5:0]  ASA_FLAGS_RST   = 6'h3f;
  localparam logic [5:0]  ASA_MASKS_RST   = 6'h3f;
  localparam logic [15:0] ASA_LANES_RST   = 16'hffff;
  localparam int          ASA_B_FIFO      = 5;
  localparam int          ASA_B_PLL       = 4;
  localparam int          ASA_B_LINK      = 3;
  localparam int          ASA_B_REALIGN   = 2;
  localparam int          ASA_B_NCO       = 1;
  localparam int          ASA_B_CLK       = 0;
  localparam int          ASA_B_SUMMARY   = 0;

  // Raw conditions from the detectors, all on the core clock
  typedef struct packed {
    logic [15:0] lane_fifo_err;
    logic        pll_locked;
    logic        link_in_encoder_state;
    logic        link_startup;
    logic        link_realign;
    logic        sysref_realign;
    logic        nco_sync;
    logic        nco_phase_mismatch;
    logic        divider_mismatch;
  } asa_cond_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ASA_AW-1:0] addr;
    logic [ASA_DW-1:0] wdata;
  } asa_req_s;

  typedef struct packed {
    logic [5:0]        flags;
    logic [5:0]        masks;
    logic [15:0]       lanes;
    logic [ASA_DW-1:0] rdata;
    logic              rvalid;
  } asa_state_s;
endpackage

// ### core/asa_event_map.sv
`timescale 1ns/10ps
// Turns raw detector conditions into per-flag set requests
module asa_event_map
  import asa_pkg::*;
(
  input  wire asa_pkg::asa_cond_s cond,
  input  wire logic               link_en,
  input  wire logic               mode_64b66b,
  output logic [5:0]              set_req
);
  always_comb begin
    set_req                = '0;
    set_req[ASA_B_FIFO]    = |cond.lane_fifo_err;
    set_req[ASA_B_PLL]     = !cond.pll_locked;
    if (mode_64b66b) begin
      set_req[ASA_B_LINK]  = cond.link_startup | cond.link_realign;
    end else begin
      set_req[ASA_B_LINK]  = link_en & !cond.link_in_encoder_state;
    end
    set_req[ASA_B_REALIGN] = cond.sysref_realign;
    set_req[ASA_B_NCO]     = !link_en | cond.nco_sync | cond.nco_phase_mismatch;
    set_req[ASA_B_CLK]     = cond.divider_mismatch;
  end
endmodule // asa_event_map

// ### core/asa_alarm_status_aggregator.sv
`timescale 1ns/10ps
// How it works
// - Summary is one when unmasked flag set
// - Summary can drive the status pin
// - Any lane FIFO error sets bit 5
// - Write one clears flag, zero keeps
// - PLL not locked sets bit 4
// - 8b/10b: enabled, not encoding sets bit 3
// - 64b/66b: startup or realign sets bit 3
// - SYSREF realignment sets bit 2
// - Link off, NCO synced or mismatched sets bit 1
// - Divider mismatch sets bit 0
// - Reset sets all six flags
// - Flags undefined while link disabled
// - Mask bit one excludes flag
// - Masks reset all set
// - Clearing bit 5 clears lane bits
module asa_alarm_status_aggregator
  import asa_pkg::*;
(
  input  wire logic               CORE_CLK,
  input  wire logic               RST,
  input  wire logic               SOFT_RST,
  input  wire asa_pkg::asa_req_s  REQ,
  output logic [ASA_DW-1:0]       RDATA,
  output logic                    RVALID,
  input  wire asa_pkg::asa_cond_s COND,
  input  wire logic               SERIAL_LINK_ENABLE,
  input  wire logic               MODE_64B66B,
  input  wire logic               STATUS_PIN_SEL_ALARM,
  input  wire logic               CAL_STATUS,
  output logic                    STATUS_OUTPUT_PIN,
  output logic [5:0]              ALARM_FLAGS,
  output logic                    ALARM_SUMMARY
);
  // All registered state lives in one struct
  asa_state_s             s_q;
  asa_state_s             s_d;

  logic [ASA_NFLAG-1:0]   set_req;
  logic [ASA_NFLAG-1:0]   clr;
  logic [ASA_NFLAG-1:0]   flags_next;
  logic [ASA_NFLAG-1:0]   masks_next;
  logic [ASA_NFLAG-1:0]   masked;

  logic [ASA_NLANE-1:0]   lane_clr;
  logic [ASA_NLANE-1:0]   lanes_next;

  logic                   wr_flags;
  logic                   wr_masks;
  logic                   wr_lanes;
  logic                   summary;

  logic [ASA_DW-1:0]      word_summary;
  logic [ASA_DW-1:0]      word_flags;
  logic [ASA_DW-1:0]      word_masks;
  logic [ASA_DW-1:0]      word_lanes;
  logic [ASA_DW-1:0]      rd_word;

  // Detectors run on this clock, so their levels need no synchroniser
  asa_event_map asa_event_map_inst (
    .cond        (COND),
    .link_en     (SERIAL_LINK_ENABLE),
    .mode_64b66b (MODE_64B66B),
    .set_req     (set_req)
  );

  // Address compare shared by every write decode
  function automatic logic hit(
    input logic [ASA_AW-1:0] addr,
    input logic [ASA_AW-1:0] ofs
  );
    hit = addr == ofs;
  endfunction

  // Six-bit registers read back with the reserved top bits at zero
  function automatic logic [ASA_DW-1:0] widen6(
    input logic [ASA_NFLAG-1:0] v
  );
    widen6 = {{(ASA_DW-ASA_NFLAG){1'b0}}, v};
  endfunction

  function automatic logic [ASA_DW-1:0] place_bit(
    input logic bit_val,
    input int   pos
  );
    place_bit      = '0;
    place_bit[pos] = bit_val;
  endfunction

  function automatic logic [ASA_NFLAG-1:0] clear_bits(
    input logic              wr,
    input logic [ASA_DW-1:0] wdata
  );
    clear_bits = '0;
    if (wr) begin
      clear_bits = wdata[ASA_NFLAG-1:0];
    end
  endfunction

  function automatic logic [ASA_NLANE-1:0] lane_clear(
    input logic              wr,
    input logic [ASA_DW-1:0] wdata,
    input logic              fifo_clr
  );
    lane_clear = '0;
    if (wr) begin
      lane_clear[ASA_DW-1:0] = wdata;
    end
    // Only the low lanes are addressable, so the flag clear must reach all of them
    if (fifo_clr) begin
      lane_clear = '1;
    end
  endfunction

  // Set is ORed in after the clear, so an event in the clear cycle is kept
  function automatic logic sticky(
    input logic held,
    input logic wipe,
    input logic raise
  );
    sticky = (held & ~wipe) | raise;
  endfunction

  function automatic logic [ASA_DW-1:0] read_mux(
    input logic [ASA_AW-1:0] addr,
    input logic [ASA_DW-1:0] w_sum,
    input logic [ASA_DW-1:0] w_flags,
    input logic [ASA_DW-1:0] w_masks,
    input logic [ASA_DW-1:0] w_lanes
  );
    case (addr)
      ASA_OFS_SUMMARY: begin
        read_mux = w_sum;
      end
      ASA_OFS_FLAGS: begin
        read_mux = w_flags;
      end
      ASA_OFS_MASKS: begin
        read_mux = w_masks;
      end
      ASA_OFS_LANES: begin
        read_mux = w_lanes;
      end
      // Unmapped addresses read as zero
      default: begin
        read_mux = '0;
      end
    endcase
  endfunction

  // Writes to the summary address or to unmapped addresses are dropped
  assign wr_flags = REQ.wr && hit(REQ.addr, ASA_OFS_FLAGS);
  assign wr_masks = REQ.wr && hit(REQ.addr, ASA_OFS_MASKS);
  assign wr_lanes = REQ.wr && hit(REQ.addr, ASA_OFS_LANES);
  assign clr      = clear_bits(wr_flags, REQ.wdata);
  assign lane_clr = lane_clear(wr_lanes, REQ.wdata, clr[ASA_B_FIFO]);

  for (genvar f = 0; f < ASA_NFLAG; f++) begin : g_flag
    assign flags_next[f] = sticky(s_q.flags[f], clr[f], set_req[f]);
    assign masked[f]     = s_q.flags[f] & ~s_q.masks[f];
  end

  // Masks are plain read/write; the reserved bits are not stored
  for (genvar m = 0; m < ASA_NFLAG; m++) begin : g_mask
    assign masks_next[m] = wr_masks ? REQ.wdata[m] : s_q.masks[m];
  end

  // Lane bits follow the same sticky rule as the flags
  for (genvar l = 0; l < ASA_NLANE; l++) begin : g_lane
    assign lanes_next[l] = sticky(s_q.lanes[l], lane_clr[l], COND.lane_fifo_err[l]);
  end

  assign summary      = |masked;
  assign word_summary = place_bit(summary, ASA_B_SUMMARY);
  assign word_flags   = widen6(s_q.flags);
  assign word_masks   = widen6(s_q.masks);
  assign word_lanes   = s_q.lanes[ASA_DW-1:0];
  assign rd_word      = read_mux(REQ.addr, word_summary, word_flags, word_masks, word_lanes);

  always_comb begin
    s_d        = s_q;
    s_d.flags  = flags_next;
    s_d.masks  = masks_next;
    s_d.lanes  = lanes_next;

    s_d.rvalid = REQ.rd;
    s_d.rdata  = '0;
    if (REQ.rd) begin
      s_d.rdata = rd_word;
    end

    // Soft reset is synchronous and wins over any write in the same cycle
    if (SOFT_RST) begin
      s_d.flags = ASA_FLAGS_RST;
      s_d.masks = ASA_MASKS_RST;
      s_d.lanes = ASA_LANES_RST;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s_q.flags  <= ASA_FLAGS_RST;
      s_q.masks  <= ASA_MASKS_RST;
      s_q.lanes  <= ASA_LANES_RST;
      s_q.rdata  <= '0;
      s_q.rvalid <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Flags other than bit 0 mean little while the link is off; software clears after enable
  assign RDATA             = s_q.rdata;
  assign RVALID            = s_q.rvalid;
  assign ALARM_FLAGS       = s_q.flags;
  assign ALARM_SUMMARY     = summary;
  assign STATUS_OUTPUT_PIN = STATUS_PIN_SEL_ALARM ? summary : CAL_STATUS;
endmodule // asa_alarm_status_aggregator

// ### testbench/asa_sva.sv
`timescale 1ns/10ps
module asa_sva
  import asa_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire logic              SOFT_RST,
  input wire asa_pkg::asa_req_s REQ,
  input wire asa_pkg::asa_cond_s COND,
  input wire logic              SERIAL_LINK_ENABLE,
  input wire logic              MODE_64B66B,
  input wire logic              STATUS_PIN_SEL_ALARM,
  input wire logic              CAL_STATUS,
  input wire logic              STATUS_OUTPUT_PIN,
  input wire logic [5:0]        ALARM_FLAGS,
  input wire logic              ALARM_SUMMARY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  logic fw;
  assign fw = REQ.wr && REQ.addr == ASA_OFS_FLAGS && !SOFT_RST;
  a_summary_cause: assert property (ALARM_SUMMARY |-> |ALARM_FLAGS)
    else $error("summary without flag");
  a_pin_select: assert property (STATUS_OUTPUT_PIN ==
    (STATUS_PIN_SEL_ALARM ? ALARM_SUMMARY : CAL_STATUS)) else $error("pin");
  a_fifo_sets: assert property (|COND.lane_fifo_err |=> ALARM_FLAGS[5])
    else $error("fifo flag");
  a_clear_one: assert property (fw && REQ.wdata[0] && !COND.divider_mismatch
    |=> !ALARM_FLAGS[0]) else $error("clear");
  a_pll_sets: assert property (!COND.pll_locked |=> ALARM_FLAGS[4])
    else $error("pll flag");
  a_link_wide: assert property (MODE_64B66B && COND.link_startup |=> ALARM_FLAGS[3])
    else $error("link flag");
  a_nco_sets: assert property (!SERIAL_LINK_ENABLE || COND.nco_sync |=> ALARM_FLAGS[1])
    else $error("nco flag");
  a_soft_restore: assert property (SOFT_RST |=> ALARM_FLAGS == 6'h3f)
    else $error("soft reset");
  a_flags_sticky: assert property (!fw && !SOFT_RST |=>
    (ALARM_FLAGS & $past(ALARM_FLAGS)) == $past(ALARM_FLAGS)) else $error("sticky");
  a_link_narrow: assert property (!MODE_64B66B && SERIAL_LINK_ENABLE
    && !COND.link_in_encoder_state |=> ALARM_FLAGS[3]) else $error("link flag narrow");
  a_link_realign: assert property (MODE_64B66B && COND.link_realign |=> ALARM_FLAGS[3])
    else $error("link realign flag");
  a_realign_sets: assert property (COND.sysref_realign |=> ALARM_FLAGS[2])
    else $error("realign flag");
  a_divider_sets: assert property (COND.divider_mismatch |=> ALARM_FLAGS[0])
    else $error("clock flag");
endmodule // asa_sva
bind asa_alarm_status_aggregator asa_sva asa_sva_inst (.*);

// ### testbench/tb_alarm_status_aggregator.sv
`timescale 1ns/10ps
module tb_alarm_status_aggregator;
  import asa_pkg::*;
  logic clk = 0, rst = 1, srst = 0, sel = 0, cal = 0, en = 1, m64 = 0, rvalid, pin, summ;
  asa_req_s req = '0;
  asa_cond_s cond, base;
  logic [7:0] rdata;
  logic [5:0] flags;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  always #4 clk = ~clk;
  asa_alarm_status_aggregator asa_alarm_status_aggregator_inst (.CORE_CLK(clk), .RST(rst),
    .SOFT_RST(srst), .REQ(req), .RDATA(rdata), .RVALID(rvalid), .COND(cond),
    .SERIAL_LINK_ENABLE(en), .MODE_64B66B(m64), .STATUS_PIN_SEL_ALARM(sel),
    .CAL_STATUS(cal), .STATUS_OUTPUT_PIN(pin), .ALARM_FLAGS(flags), .ALARM_SUMMARY(summ));
  task test_done;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_bit(input logic got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk) req = '{1'b1, 1'b0, a, d};
    @(negedge clk) req = '0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk) req = '0;
    chk_bit(rvalid, 1'b1);
    chk(rdata, e);
  endtask
  always @(posedge clk) if (++cyc == 5000) begin
    n_fail++;
    test_done;
  end
  initial begin
    base = '0;
    base.pll_locked = 1;
    base.link_in_encoder_state = 1;
    cond = base;
    repeat (4) @(negedge clk);
    rst = 0;
    rd(ASA_OFS_FLAGS, 8'h3f);
    rd(ASA_OFS_MASKS, 8'h3f);
    rd(ASA_OFS_SUMMARY, 8'h00);
    wr(ASA_OFS_FLAGS, 8'h3f);
    wr(ASA_OFS_MASKS, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      case (i)
        0: cond.divider_mismatch = 1;
        1: cond.nco_sync = 1;
        2: cond.sysref_realign = 1;
        3: cond.link_in_encoder_state = 0;
        4: cond.pll_locked = 0;
        5: cond.lane_fifo_err = 16'h0004;
      endcase
      @(negedge clk) cond = base;
      rd(ASA_OFS_FLAGS, 8'h01 << i);
      chk({2'b00, flags}, 8'h01 << i);
      rd(ASA_OFS_SUMMARY, 8'h01);
      chk_bit(summ, 1'b1);
      wr(ASA_OFS_MASKS, 8'h01 << i);
      rd(ASA_OFS_SUMMARY, 8'h00);
      chk_bit(summ, 1'b0);
      wr(ASA_OFS_FLAGS, ~(8'h01 << i));
      rd(ASA_OFS_FLAGS, 8'h01 << i);
      if (i == 5) rd(ASA_OFS_LANES, 8'h04);
      wr(ASA_OFS_FLAGS, 8'h01 << i);
      rd(ASA_OFS_FLAGS, 8'h00);
      wr(ASA_OFS_MASKS, 8'h00);
    end
    rd(ASA_OFS_LANES, 8'h00);
    rd(12'h2c3, 8'h00);
    m64 = 1;
    @(negedge clk) cond.link_startup = 1;
    @(negedge clk) cond = base;
    rd(ASA_OFS_FLAGS, 8'h08);
    wr(ASA_OFS_FLAGS, 8'h08);
    @(negedge clk) cond.link_realign = 1;
    @(negedge clk) cond = base;
    rd(ASA_OFS_FLAGS, 8'h08);
    wr(ASA_OFS_FLAGS, 8'h08);
    m64 = 0;
    en = 0;
    rd(ASA_OFS_FLAGS, 8'h02);
    en = 1;
    wr(ASA_OFS_FLAGS, 8'h02);
    cond.divider_mismatch = 1;
    @(negedge clk) cond = base;
    chk_bit(summ, 1'b1);
    chk_bit(pin, 1'b0);
    sel = 1;
    @(negedge clk) chk_bit(pin, 1'b1);
    cal = 1;
    srst = 1;
    @(negedge clk) srst = 0;
    rd(ASA_OFS_FLAGS, 8'h3f);
    chk_bit(summ, 1'b0);
    chk_bit(pin, 1'b0);
    test_done;
  end
endmodule // tb_alarm_status_aggregator
